// ===== common/fsp_defs.svh
// fsp_defs.svh: offsets, field positions, key values and counts
// assumes: included by bare name from design and testbench files
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
// ********************
// register offsets
// ********************
`define FSP_OFF_ADDR_LOW 4'h0
`define FSP_OFF_ADDR_HIGH 4'h1
`define FSP_OFF_DATA_FIRST 4'h2
`define FSP_OFF_DATA_LAST 4'h9
`define FSP_OFF_D0_HIGH 4'h3
`define FSP_OFF_KEY_FIRST 4'h4
`define FSP_OFF_CTRL 4'ha
`define FSP_OFF_RESET_KEY 4'hb
`define FSP_OFF_CLEAR 4'hc
// ********************
// operation_control fields
// ********************
`define FSP_BIT_UNLOCK 7
`define FSP_BIT_MODE_HI 6
`define FSP_BIT_MODE_LO 4
`define FSP_BIT_TRIGGER 3
`define FSP_BIT_EW_START 2
`define FSP_BIT_RD_EN 1
`define FSP_BIT_RD_START 0
`define FSP_BIT_CLEAR 0
// ********************
// mode codes, keys, reset values
// ********************
`define FSP_MODE_WRITE 3'h0
`define FSP_MODE_ERASE 3'h1
`define FSP_MODE_READ 3'h3
`define FSP_MODE_UNLOCK 3'h6
`define FSP_KEY1_LOW 8'h00
`define FSP_KEY2_LOW 8'h0d
`define FSP_KEY3_LOW 8'hc3
`define FSP_KEY1_HIGH 8'h04
`define FSP_KEY2_HIGH 8'h09
`define FSP_KEY3_HIGH 8'h40
`define FSP_CHIP_RESET_KEY 8'h55
`define FSP_RESET_BYTE 8'h00
`define FSP_PAGE_LAST 5'h1f
// ********************
// timing counts in clk cycles
// ********************
`define FSP_UNLOCK_CYCLES 10'd64
`define FSP_ERASE_CYCLES 10'd400
`define FSP_WRITE_CYCLES 10'd200
`define FSP_READ_CYCLES 10'd3
`endif

// ===== common/fsp_pkg.sv
// fsp_pkg: types shared by the self-programming controller
// assumes: fsp_defs.svh holds offsets, keys and counts; the encodings below are local
package fsp_pkg;
    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } fsp_bus_t;
    // operation toward the array
    typedef enum logic [1:0] {
        FSP_OP_READ = 2'h0,
        FSP_OP_WRITE = 2'h1,
        FSP_OP_ERASE = 2'h2
    } fsp_op_t;
    typedef struct packed {
        logic valid;
        fsp_op_t op;
        logic [11:0] addr;
        logic [15:0] data;
        logic [31:0] erase_mask;
    } fsp_arr_req_t;
    typedef enum logic [5:0] {
        FSP_ST_IDLE = 6'h01,
        FSP_ST_ERASE = 6'h02,
        FSP_ST_WFETCH = 6'h04,
        FSP_ST_WISSUE = 6'h08,
        FSP_ST_WWAIT = 6'h10,
        FSP_ST_READ = 6'h20
    } fsp_state_t;
endpackage : fsp_pkg

// ===== design/fsp_ctrl.sv
// fsp_ctrl: firmware self-programming controller for the program flash
// assumes: byte register port, array answers reads within one cycle
// Behaviour
// RULE1: software writing one to unlock status does nothing, zero clears it
// RULE2: only a correct unlock sequence sets unlock status
// RULE3: mode 000 write, 001 erase, 011 read, 110 unlock, rest reserved
// RULE4: software unlocks before any erase or write
// RULE5: unlock trigger starts a timer, hardware clears trigger at expiry
// RULE6: six key bytes must hold the fixed pattern before expiry
// RULE7: trigger clears at expiry whatever the keys hold
// RULE8: wrong keys leave erase and write disabled, retry allowed
// RULE9: software selects unlock mode, sets trigger, then writes keys
// RULE10: erase/write start launches selected operation, clears when done
// RULE11: reads happen only with read enable high
// RULE12: read start launches a read, clears when it finishes
// RULE13: software never sets both starts and read enable in one write
// RULE14: processor stalls while an operation runs
// RULE15: writing 55h to the reset key resets the chip
// RULE16: buffer clear bit clears the buffer then drops, upper bits zero
// RULE17: high data writes tag erase addresses, address stops at 11111b
// RULE18: erased words read back as 0000h
// RULE19: buffer holds one 32-word page chosen by address bits 11 to 5
// RULE20: software clears buffer and rewrites after a failed verify
// RULE21: software erases a page before writing it
// RULE22: high data write loads word into buffer and bumps address
// RULE23: buffer clears itself when a write finishes
// RULE24: finished read leaves the word in the first data pair
// RULE25: a read takes about three cycles from start to clear
// RULE26: start with no unlock or reserved mode only clears the bit
// RULE27: erase and write durations are named counts
`timescale 1ns/10ps
`include "fsp_defs.svh"
module fsp_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire fsp_pkg::fsp_bus_t bus,
    output logic [7:0] rdata,
    // system
    output logic stall,
    output logic chip_reset,
    // flash array
    output fsp_pkg::fsp_arr_req_t arr_req,
    input wire logic [15:0] arr_rdata
);
    // ********************
    // state
    // ********************
    fsp_pkg::fsp_state_t state_reg, state_next;
    fsp_pkg::fsp_arr_req_t arr_reg, arr_next;
    logic [11:0] addr_reg;
    logic [7:0] data_reg [0:7];
    logic [5:0] key_seen_reg;
    logic unlock_reg, trig_reg, ew_start_reg, rd_en_reg, rd_start_reg;
    logic [2:0] mode_reg;
    logic clr_reg, chip_rst_reg;
    logic [7:0] rkey_reg, rdata_reg;
    logic [31:0] tag_reg;
    logic [9:0] utimer_reg, cnt_reg, cnt_next;
    logic [4:0] widx_reg, widx_next;
    logic [15:0] buf_rdata;

    // ********************
    // decode
    // ********************
    wire [7:0] wd = bus.wdata;
    wire ctrl_wr = bus.wr && bus.addr == `FSP_OFF_CTRL;
    wire clr_wr = bus.wr && bus.addr == `FSP_OFF_CLEAR;
    wire rkey_wr = bus.wr && bus.addr == `FSP_OFF_RESET_KEY;
    wire alo_wr = bus.wr && bus.addr == `FSP_OFF_ADDR_LOW;
    wire ahi_wr = bus.wr && bus.addr == `FSP_OFF_ADDR_HIGH;
    wire d0h_wr = bus.wr && bus.addr == `FSP_OFF_D0_HIGH;
    wire data_wr = bus.wr && bus.addr >= `FSP_OFF_DATA_FIRST
        && bus.addr <= `FSP_OFF_DATA_LAST;
    wire key_wr = bus.wr && bus.addr >= `FSP_OFF_KEY_FIRST
        && bus.addr <= `FSP_OFF_DATA_LAST;
    wire [2:0] didx = 3'(bus.addr - `FSP_OFF_DATA_FIRST);
    wire [2:0] kidx = 3'(bus.addr - `FSP_OFF_KEY_FIRST);
    wire idle = state_reg == fsp_pkg::FSP_ST_IDLE;
    wire [2:0] wd_mode = wd[`FSP_BIT_MODE_HI:`FSP_BIT_MODE_LO];
    wire [2:0] mode_now = ctrl_wr ? wd_mode : mode_reg;
    // the forbidden triple sets neither start bit; mode and read enable still load
    wire all3 = wd[`FSP_BIT_EW_START] && wd[`FSP_BIT_RD_EN]
        && wd[`FSP_BIT_RD_START];

    // ********************
    // unlock sequence
    // ********************
    wire key_good = data_reg[2] == `FSP_KEY1_LOW
        && data_reg[4] == `FSP_KEY2_LOW && data_reg[6] == `FSP_KEY3_LOW
        && data_reg[3] == `FSP_KEY1_HIGH && data_reg[5] == `FSP_KEY2_HIGH
        && data_reg[7] == `FSP_KEY3_HIGH && &key_seen_reg; // RULE6
    wire trig_go = ctrl_wr && wd[`FSP_BIT_TRIGGER] && !trig_reg
        && mode_now == `FSP_MODE_UNLOCK;
    wire expire = trig_reg && utimer_reg == 10'd0; // RULE5
    wire unlock_set = expire && key_good && mode_reg == `FSP_MODE_UNLOCK;
    wire unlock_clr = ctrl_wr && !wd[`FSP_BIT_UNLOCK];

    // trigger and window timer; keys must all land inside the window
    always_ff @(posedge clk) begin
        if (rst) begin
            trig_reg <= 1'b0;
            utimer_reg <= 10'd0;
            key_seen_reg <= 6'h00;
        end else if (trig_go) begin
            trig_reg <= 1'b1;
            utimer_reg <= `FSP_UNLOCK_CYCLES - 10'd1;
            key_seen_reg <= 6'h00;
        end else begin
            if (expire) trig_reg <= 1'b0; // RULE7
            if (trig_reg && !expire) utimer_reg <= utimer_reg - 10'd1;
            if (key_wr && trig_reg) key_seen_reg[kidx] <= 1'b1;
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) unlock_reg <= 1'b0;
        else if (unlock_set) unlock_reg <= 1'b1; // RULE2
        else if (unlock_clr) unlock_reg <= 1'b0; // RULE1 RULE8
    end

    // ********************
    // operation control bits
    // ********************
    wire ew_ok = unlock_reg && (mode_reg == `FSP_MODE_WRITE
        || mode_reg == `FSP_MODE_ERASE); // RULE3 RULE26
    wire rd_ok = rd_en_reg && mode_reg == `FSP_MODE_READ; // RULE11
    wire ew_launch = idle && ew_start_reg;
    wire rd_launch = idle && rd_start_reg && !ew_start_reg;
    wire ew_done = (state_reg == fsp_pkg::FSP_ST_ERASE
        || state_reg == fsp_pkg::FSP_ST_WWAIT) && cnt_reg == 10'd0;
    wire rd_done = state_reg == fsp_pkg::FSP_ST_READ && cnt_reg == 10'd0;

    // start bits fall on completion, or at once when nothing may launch
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= 3'h0;
            rd_en_reg <= 1'b0;
            ew_start_reg <= 1'b0;
            rd_start_reg <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                mode_reg <= wd_mode;
                rd_en_reg <= wd[`FSP_BIT_RD_EN];
            end
            if (ctrl_wr && idle && !all3 && wd[`FSP_BIT_EW_START])
                ew_start_reg <= 1'b1;
            else if (ew_done || (ew_launch && !ew_ok))
                ew_start_reg <= 1'b0; // RULE10 RULE26
            if (ctrl_wr && idle && !all3 && wd[`FSP_BIT_RD_START])
                rd_start_reg <= 1'b1;
            else if (rd_done || (rd_launch && !rd_ok))
                rd_start_reg <= 1'b0; // RULE11 RULE12
        end
    end

    // ********************
    // sequencer
    // ********************
    wire [4:0] tag_idx = widx_reg;
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        widx_next = widx_reg;
        arr_next = arr_reg;
        arr_next.valid = 1'b0;
        case (state_reg)
            fsp_pkg::FSP_ST_IDLE: begin
                if (ew_launch && ew_ok && mode_reg == `FSP_MODE_ERASE) begin
                    state_next = fsp_pkg::FSP_ST_ERASE;
                    cnt_next = `FSP_ERASE_CYCLES - 10'd1; // RULE27
                    arr_next.valid = 1'b1;
                    arr_next.op = fsp_pkg::FSP_OP_ERASE;
                    arr_next.addr = {addr_reg[11:5], 5'h00};
                    arr_next.erase_mask = tag_reg; // RULE17 RULE18
                end else if (ew_launch && ew_ok) begin
                    state_next = fsp_pkg::FSP_ST_WFETCH;
                    widx_next = 5'h00;
                end else if (rd_launch && rd_ok) begin
                    state_next = fsp_pkg::FSP_ST_READ;
                    cnt_next = `FSP_READ_CYCLES - 10'd2; // RULE25
                    arr_next.valid = 1'b1;
                    arr_next.op = fsp_pkg::FSP_OP_READ;
                    arr_next.addr = addr_reg;
                end
            end
            fsp_pkg::FSP_ST_WFETCH: begin
                state_next = fsp_pkg::FSP_ST_WISSUE;
            end
            fsp_pkg::FSP_ST_WISSUE: begin
                // only tagged words of the buffered page go out
                arr_next.valid = tag_reg[tag_idx];
                arr_next.op = fsp_pkg::FSP_OP_WRITE;
                arr_next.addr = {addr_reg[11:5], widx_reg}; // RULE19
                arr_next.data = buf_rdata;
                widx_next = widx_reg + 5'h01;
                if (widx_reg == `FSP_PAGE_LAST) begin
                    state_next = fsp_pkg::FSP_ST_WWAIT;
                    cnt_next = `FSP_WRITE_CYCLES - 10'd1; // RULE27
                end else begin
                    state_next = fsp_pkg::FSP_ST_WFETCH;
                end
            end
            fsp_pkg::FSP_ST_ERASE, fsp_pkg::FSP_ST_WWAIT,
            fsp_pkg::FSP_ST_READ: begin
                arr_next.valid = state_reg == fsp_pkg::FSP_ST_READ;
                if (cnt_reg == 10'd0) state_next = fsp_pkg::FSP_ST_IDLE;
                else cnt_next = cnt_reg - 10'd1;
            end
            default: begin
                state_next = fsp_pkg::FSP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= fsp_pkg::FSP_ST_IDLE;
            cnt_reg <= 10'd0;
            widx_reg <= 5'h00;
            arr_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            widx_reg <= widx_next;
            arr_reg <= arr_next;
        end
    end
    assign arr_req = arr_reg;
    assign stall = !idle; // RULE14

    // ********************
    // address, data and write buffer
    // ********************
    wire buf_load = d0h_wr && unlock_reg && idle; // RULE22
    wire at_last = addr_reg[4:0] == `FSP_PAGE_LAST;
    wire tags_clear = clr_reg || ew_done; // RULE16 RULE23

    // the address stops at the page end instead of wrapping
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_reg <= 12'h000;
        end else if (alo_wr) begin
            addr_reg[7:0] <= wd;
        end else if (ahi_wr) begin
            addr_reg[11:8] <= wd[3:0];
        end else if (d0h_wr && !at_last) begin
            addr_reg <= addr_reg + 12'h001; // RULE17 RULE22
        end
    end

    // a finished read overwrites the first data pair
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) data_reg[i] <= `FSP_RESET_BYTE;
        end else if (rd_done) begin
            data_reg[0] <= arr_rdata[7:0]; // RULE24
            data_reg[1] <= arr_rdata[15:8];
        end else if (data_wr) begin
            data_reg[didx] <= wd;
        end
    end

    // a new tag wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) tag_reg <= 32'h00000000;
        else tag_reg <= (tags_clear ? 32'h00000000 : tag_reg)
            | (buf_load ? 32'h00000001 << addr_reg[4:0] : 32'h00000000);
    end

    fsp_wbuf u_wbuf (
        .clk(clk),
        .rst(rst),
        .we(buf_load),
        .waddr(addr_reg[4:0]),
        .wdata({wd, data_reg[0]}),
        .raddr(widx_reg),
        .rdata(buf_rdata)
    );

    // ********************
    // clear, chip reset and read back
    // ********************
    always_ff @(posedge clk) begin
        if (rst) begin
            clr_reg <= 1'b0;
            rkey_reg <= `FSP_RESET_BYTE;
            chip_rst_reg <= 1'b0;
        end else begin
            clr_reg <= clr_wr && wd[`FSP_BIT_CLEAR]; // RULE16
            if (rkey_wr) rkey_reg <= wd;
            chip_rst_reg <= rkey_wr && wd == `FSP_CHIP_RESET_KEY; // RULE15
        end
    end
    assign chip_reset = chip_rst_reg;

    wire [7:0] ctrl_rd = {unlock_reg, mode_reg, trig_reg, ew_start_reg,
        rd_en_reg, rd_start_reg};
    wire [7:0] rd_mux =
        bus.addr == `FSP_OFF_ADDR_LOW ? addr_reg[7:0] :
        bus.addr == `FSP_OFF_ADDR_HIGH ? {4'h0, addr_reg[11:8]} :
        (bus.addr >= `FSP_OFF_DATA_FIRST && bus.addr <= `FSP_OFF_DATA_LAST)
            ? data_reg[didx] :
        bus.addr == `FSP_OFF_CTRL ? ctrl_rd :
        bus.addr == `FSP_OFF_RESET_KEY ? rkey_reg :
        bus.addr == `FSP_OFF_CLEAR ? {7'h00, clr_reg} : 8'h00;

    // data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) rdata_reg <= 8'h00;
        else rdata_reg <= bus.rd ? rd_mux : 8'h00;
    end
    assign rdata = rdata_reg;

    // ********************
    // assertions
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sw_set_a: assert property ( // RULE1
        ctrl_wr && wd[7] && !unlock_reg && !unlock_set |=> !unlock_reg)
        else $error("software set unlock status");
    sw_clr_a: assert property ( // RULE1
        unlock_clr && !unlock_set |=> !unlock_reg)
        else $error("unlock status not cleared");
    unlock_src_a: assert property ( // RULE2
        $rose(unlock_reg) |-> $past(expire) && $past(key_good))
        else $error("unlock without good keys");
    trig_len_a: assert property ( // RULE5
        $rose(trig_reg) |-> ##63 trig_reg ##1 !trig_reg)
        else $error("unlock window length wrong");
    bad_key_a: assert property ( // RULE8
        expire && !key_good && !unlock_reg |=> !unlock_reg)
        else $error("wrong keys unlocked");
    reserved_a: assert property ( // RULE26
        ew_launch && !ew_ok |=> idle && !ew_start_reg && !arr_req.valid)
        else $error("blocked start launched");
    rd_inhibit_a: assert property ( // RULE11
        rd_launch && !rd_en_reg |=> idle && !rd_start_reg)
        else $error("read ran without enable");
    rd_time_a: assert property ( // RULE25
        rd_launch && rd_ok |=> stall ##1 rd_start_reg ##1 !rd_start_reg)
        else $error("read length wrong");
    erase_go_a: assert property ( // RULE3
        ew_launch && ew_ok && mode_reg == `FSP_MODE_ERASE
        |=> arr_req.valid && arr_req.op == fsp_pkg::FSP_OP_ERASE)
        else $error("erase not issued");
    stall_a: assert property ( // RULE14
        (ew_launch && ew_ok) || (rd_launch && rd_ok) |=> stall)
        else $error("no stall after launch");
    chip_rst_a: assert property ( // RULE15
        rkey_wr |=> chip_reset == ($past(wd) == `FSP_CHIP_RESET_KEY))
        else $error("chip reset wrong");
    hold_a: assert property ( // RULE17
        d0h_wr && at_last && !alo_wr |=> addr_reg[4:0] == `FSP_PAGE_LAST)
        else $error("address left page");
    addr_inc_a: assert property ( // RULE22
        d0h_wr && !at_last |=> addr_reg == $past(addr_reg) + 12'h001)
        else $error("address not incremented");
    wr_clear_a: assert property ( // RULE23
        state_reg == fsp_pkg::FSP_ST_WWAIT && cnt_reg == 10'd0
        |=> tag_reg == 32'h00000000 && !ew_start_reg)
        else $error("buffer not cleared after write");

    unlock_c: cover property ($rose(unlock_reg));
    erase_c: cover property (state_reg == fsp_pkg::FSP_ST_ERASE);
    write_c: cover property (arr_req.valid
        && arr_req.op == fsp_pkg::FSP_OP_WRITE);
    read_c: cover property (rd_done);
endmodule : fsp_ctrl

// ===== design/fsp_wbuf.sv
// fsp_wbuf: 32 x 16 write buffer, one write and one registered read port
// assumes: single clock, contents need no reset
`timescale 1ns/10ps
module fsp_wbuf (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write port
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [15:0] wdata,
    // read port
    input wire logic [4:0] raddr,
    output logic [15:0] rdata
);
    logic [15:0] mem_reg [0:31];
    logic [15:0] rdata_reg;

    // contents are untouched by reset; the tag mask says what is valid
    always_ff @(posedge clk) begin
        if (we) begin
            mem_reg[waddr] <= wdata;
        end
    end

    // read data appear one cycle after the address
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= mem_reg[raddr];
        end
    end
    assign rdata = rdata_reg;
endmodule : fsp_wbuf

// ===== testbench/fsp_array_model.sv
// fsp_array_model: behavioural program flash array behind fsp_ctrl
// assumes: one command per cycle, reads answered the cycle after valid
`timescale 1ns/10ps
module fsp_array_model (
    // clock
    input wire logic clk,
    // command from the controller
    input wire fsp_pkg::fsp_arr_req_t req,
    // read data back
    output logic [15:0] rdata
);
    // ********************
    // storage and command handling
    // ********************
    logic [15:0] mem [0:4095];
    logic rd_hit;
    logic wr_hit;
    logic er_hit;
    assign rd_hit = req.valid && (req.op == fsp_pkg::FSP_OP_READ);
    assign wr_hit = req.valid && (req.op == fsp_pkg::FSP_OP_WRITE);
    assign er_hit = req.valid && (req.op == fsp_pkg::FSP_OP_ERASE);
    // non-blank start pattern so an erase that misses a word shows up
    initial begin
        rdata = 16'h0000;
        for (int i = 0; i < 4096; i++) begin
            mem[i] = {4'ha, 12'(i)};
        end
    end
    // outside a read the data lines toggle, never hold a stale word
    always @(posedge clk) begin
        if (rd_hit) begin
            rdata <= mem[req.addr];
        end else begin
            rdata <= ~rdata;
        end
        if (wr_hit) begin
            mem[req.addr] <= req.data;
        end
        if (er_hit) begin
            for (int i = 0; i < 32; i++) begin
                if (req.erase_mask[i]) begin
                    mem[{req.addr[11:5], 5'(i)}] <= 16'h0000;
                end
            end
        end
    end
endmodule : fsp_array_model

// ===== testbench/testbench.sv
// testbench: self-checking bench for fsp_ctrl with the array model
// assumes: 200 MHz clock, register port strobes one cycle long
`timescale 1ns/10ps
`include "fsp_defs.svh"
module testbench;
    // ********************
    // signals and instances
    // ********************
    logic clk = 1'b0;
    logic rst = 1'b1;
    fsp_pkg::fsp_bus_t bus = '0;
    logic [7:0] rdata;
    logic stall;
    logic chip_reset;
    fsp_pkg::fsp_arr_req_t arr_req;
    logic [15:0] arr_rdata;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int stall_run = 0;
    logic last_cr = 1'b0;
    always #2.5 clk = ~clk;
    fsp_ctrl dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
        .stall(stall), .chip_reset(chip_reset), .arr_req(arr_req),
        .arr_rdata(arr_rdata));
    fsp_array_model array (.clk(clk), .req(arr_req), .rdata(arr_rdata));
    // watchdog, plus a running count of stalled cycles for length checks
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (stall === 1'b1) begin
            stall_run <= stall_run + 1;
        end
        if (cycles == 5000) begin
            n_errors++;
            final_report();
        end
    end
    // ********************
    // helpers
    // ********************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check
    // every access leaves one idle cycle behind it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        last_cr = chip_reset;
        @(posedge clk);
    endtask : wr
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
        check({8'h00, d}, {8'h00, exp});
    endtask : rdchk
    task automatic set_addr(input logic [11:0] a);
        wr(`FSP_OFF_ADDR_LOW, a[7:0]);
        wr(`FSP_OFF_ADDR_HIGH, {4'h0, a[11:8]});
    endtask : set_addr
    // bounded wait for stall to drop
    task automatic wait_op();
        @(negedge clk);
        for (int i = 0; i < 1000 && stall !== 1'b0; i++) begin
            @(negedge clk);
        end
        check({15'h0, stall}, 16'h0000);
        @(posedge clk);
    endtask : wait_op
    task automatic read_word(input logic [11:0] a, input logic [15:0] exp);
        int s0;
        set_addr(a);
        s0 = stall_run;
        wr(`FSP_OFF_CTRL, 8'hb3);
        wait_op();
        check(16'(stall_run - s0), 16'h0002);
        rdchk(`FSP_OFF_CTRL, 8'hb2);
        rdchk(`FSP_OFF_DATA_FIRST, exp[7:0]);
        rdchk(`FSP_OFF_D0_HIGH, exp[15:8]);
    endtask : read_word
    // unlock attempt with the last key byte chosen by the caller
    task automatic unlock(input logic [7:0] last_key);
        logic [7:0] keys [0:5];
        keys = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, last_key};
        wr(`FSP_OFF_CTRL, 8'h68);
        for (int i = 0; i < 6; i++) begin
            wr(`FSP_OFF_KEY_FIRST + 4'(i), keys[i]);
        end
        rdchk(`FSP_OFF_CTRL, 8'h68);
        repeat (64) @(posedge clk);
    endtask : unlock
    // ********************
    // scenarios
    // ********************
    task automatic t_reset();
        rdchk(`FSP_OFF_CTRL, 8'h00);
        rdchk(`FSP_OFF_CLEAR, 8'h00);
        rdchk(4'hd, 8'h00);
        wr(`FSP_OFF_RESET_KEY, 8'h54);
        check({15'h0, last_cr}, 16'h0000);
        wr(`FSP_OFF_RESET_KEY, 8'h55);
        check({15'h0, last_cr}, 16'h0001);
        wr(`FSP_OFF_CTRL, 8'h80);
        rdchk(`FSP_OFF_CTRL, 8'h00);
        wr(`FSP_OFF_CTRL, 8'h14);
        rdchk(`FSP_OFF_CTRL, 8'h10);
        $display("test reset and locked start done");
    endtask : t_reset
    task automatic t_unlock();
        unlock(8'h41);
        rdchk(`FSP_OFF_CTRL, 8'h60);
        unlock(8'h40);
        rdchk(`FSP_OFF_CTRL, 8'he0);
        $display("test unlock done");
    endtask : t_unlock
    task automatic t_erase();
        int s0;
        wr(`FSP_OFF_CTRL, 8'ha4);
        rdchk(`FSP_OFF_CTRL, 8'ha0);
        wr(`FSP_OFF_CTRL, 8'h90);
        set_addr(12'h040);
        repeat (3) wr(`FSP_OFF_D0_HIGH, 8'hff);
        rdchk(`FSP_OFF_ADDR_LOW, 8'h43);
        set_addr(12'h05e);
        repeat (3) wr(`FSP_OFF_D0_HIGH, 8'hff);
        rdchk(`FSP_OFF_ADDR_LOW, 8'h5f);
        s0 = stall_run;
        wr(`FSP_OFF_CTRL, 8'h94);
        wait_op();
        check(16'(stall_run - s0), 16'(`FSP_ERASE_CYCLES));
        rdchk(`FSP_OFF_CTRL, 8'h90);
        $display("test erase done");
    endtask : t_erase
    task automatic t_read();
        int s0;
        read_word(12'h041, 16'h0000);
        read_word(12'h05f, 16'h0000);
        read_word(12'h045, 16'ha045);
        wr(`FSP_OFF_CTRL, 8'hb0);
        set_addr(12'h046);
        s0 = stall_run;
        wr(`FSP_OFF_CTRL, 8'hb1);
        rdchk(`FSP_OFF_CTRL, 8'hb0);
        rdchk(`FSP_OFF_DATA_FIRST, 8'h45);
        check(16'(stall_run - s0), 16'h0000);
        wr(`FSP_OFF_CTRL, 8'hb7);
        rdchk(`FSP_OFF_CTRL, 8'hb2);
        $display("test read done");
    endtask : t_read
    task automatic t_write();
        int s0;
        wr(`FSP_OFF_CTRL, 8'h80);
        set_addr(12'h042);
        wr(`FSP_OFF_D0_HIGH, 8'hee);
        wr(`FSP_OFF_CLEAR, 8'h01);
        rdchk(`FSP_OFF_CLEAR, 8'h00);
        set_addr(12'h040);
        wr(`FSP_OFF_DATA_FIRST, 8'h34);
        wr(`FSP_OFF_D0_HIGH, 8'h12);
        wr(`FSP_OFF_DATA_FIRST, 8'h78);
        wr(`FSP_OFF_D0_HIGH, 8'h56);
        rdchk(`FSP_OFF_ADDR_LOW, 8'h42);
        s0 = stall_run;
        wr(`FSP_OFF_CTRL, 8'h84);
        wait_op();
        check(16'(stall_run - s0), 16'(`FSP_WRITE_CYCLES) + 16'd64);
        rdchk(`FSP_OFF_CTRL, 8'h80);
        wr(`FSP_OFF_CTRL, 8'hb2);
        read_word(12'h040, 16'h1234);
        read_word(12'h041, 16'h5678);
        read_word(12'h042, 16'h0000);
        wr(`FSP_OFF_CTRL, 8'h00);
        rdchk(`FSP_OFF_CTRL, 8'h00);
        $display("test write done");
    endtask : t_write
    // ********************
    // sequence and verdict
    // ********************
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_unlock();
        t_erase();
        t_read();
        t_write();
        final_report();
    end
endmodule : testbench
